// ### rtl/lsw_ctrl.sv
// Functional notes
// - After reset input A drives channel 2 and input B channel 3.
// - A channel is on when its enable bit or any mapped input is high.
// - Two route registers choose which channels each input pin drives.
// - Input monitor shows both input levels, also in limp home.
// - Sleep low with an input high enters limp home, default channels follow the inputs.
// - Limp home routes inputs straight to channels 2 and 3, unless both supplies are low.
// - Sleep low with both inputs low enters sleep mode.
// - Sleep pin low returns all serial registers to defaults.
// - Sleep mode disables undervoltage detection.
// - Sleep mode refuses serial traffic; serial output stays undriven.
// - Overcurrent turns a channel off until re-enabled over the serial link.
// - In limp home a tripped, input-driven channel restarts after the restart time.
// - Restart time register selects 10, 20, 40 or 80 ms; limp home holds it at the 10 ms default.
// - Off-state current source only switched on when commanded.
// - Both supplies low: stages off, serial blocked, registers reset.
// - Digital supply low: serial blocked, registers reset.
// - Analog supply low: on channels stay on, off channels may not turn on.
// - 16-bit frames, daisy-chain capable, frame length a multiple of 16 bits only.
// - Serial interface works only while the digital supply is present.
`timescale 1ns/10ps
module lsw_ctrl #(
    parameter int RETRY_BASE_CYCLES = lsw_pkg::RETRY0_CYCLES,
    parameter int TIMER_W = lsw_pkg::RETRY_TIMER_W
) (
    input wire logic CLK, // core clock, 40 MHz
    input wire logic NRST, // async reset, active low
    input wire logic SCLK, // serial clock from controller
    input wire logic CHIP_SELECT_N, // serial frame select, active low
    input wire logic SDI, // serial data in
    output logic SDO, // serial data out
    output logic SDO_OE, // serial output enable, high drives
    input wire logic DIRECT_INPUT_A, // direct input pin a
    input wire logic DIRECT_INPUT_B, // direct input pin b
    input wire logic SLEEP_REQUEST_N, // sleep pin, active low
    input wire logic DIGITAL_SUPPLY_UV, // digital supply undervoltage
    input wire logic ANALOG_SUPPLY_UV, // analog supply undervoltage
    input wire logic ANALOG_SUPPLY_LOW, // analog supply below operating level
    input wire logic [lsw_pkg::NUM_CH-1:0] OVERCURRENT, // per-channel threshold hit
    output logic [lsw_pkg::NUM_CH-1:0] CHANNEL_ON, // power stage gate commands
    output logic [lsw_pkg::NUM_CH-1:0] CURRENT_SOURCE_ON, // open-load current sources
    output logic [lsw_pkg::NUM_CH-1:0] OC_LATCHED, // channels held off by protection
    output logic UV_DETECT_ENABLE, // undervoltage detectors powered
    output lsw_pkg::lsw_mode_t MODE // present operating mode
);
    import lsw_pkg::*;

    typedef struct packed {
        logic [PIN_W-1:0] pin_meta;
        logic [PIN_W-1:0] pin_sync;
        logic cs_prev;
        lsw_mode_t mode;
        logic [NUM_CH-1:0] enable;
        logic [NUM_CH-1:0] route_a;
        logic [NUM_CH-1:0] route_b;
        logic [NUM_CH-1:0] cur_src;
        logic [1:0] retry_sel;
        logic [NUM_CH-1:0] latch;
        logic [ADDR_W-1:0] rd_addr;
        logic [FRAME_BITS-1:0] resp;
        logic [NUM_CH-1:0] chan;
        logic [NUM_CH-1:0] isrc;
        logic sdo_oe;
        logic uv_en;
    } lsw_state_t;

    lsw_state_t st;
    lsw_state_t next_st;

    logic [FRAME_BITS-1:0] frame_word;
    logic frame_ok;
    logic [NUM_CH-1:0] retry_done;
    logic [NUM_CH-1:0] retry_run;
    logic [TIMER_W-1:0] retry_limit;
    logic [PIN_W-1:0] pin_raw;

    // synchronised pin levels
    logic cs_n;
    logic in_a;
    logic in_b;
    logic sleep_n;
    logic dig_uv;
    logic ana_uv;
    logic ana_low;
    logic [NUM_CH-1:0] oc;

    // decoded frame and working values
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic frame_take;
    logic spi_ok;
    logic regs_clr;
    logic [NUM_CH-1:0] limp_dem;
    logic [NUM_CH-1:0] norm_dem;
    logic [NUM_CH-1:0] demand;
    logic [NUM_CH-1:0] oc_set;
    logic [NUM_CH-1:0] oc_clr;
    logic [DATA_W-1:0] rd_data;

    assign pin_raw = {OVERCURRENT, ANALOG_SUPPLY_LOW, ANALOG_SUPPLY_UV, DIGITAL_SUPPLY_UV,
                      SLEEP_REQUEST_N, DIRECT_INPUT_B, DIRECT_INPUT_A, CHIP_SELECT_N};

    assign cs_n = st.pin_sync[PIN_CS];
    assign in_a = st.pin_sync[PIN_IN_A];
    assign in_b = st.pin_sync[PIN_IN_B];
    assign sleep_n = st.pin_sync[PIN_SLEEP_N];
    assign dig_uv = st.pin_sync[PIN_DIG_UV];
    assign ana_uv = st.pin_sync[PIN_ANA_UV];
    assign ana_low = st.pin_sync[PIN_ANA_LOW];
    assign oc = st.pin_sync[PIN_OC_LO +: NUM_CH];

    // each step of the selector doubles the base interval
    assign retry_limit = TIMER_W'(RETRY_BASE_CYCLES) << st.retry_sel;

    lsw_spi_link u_link (
        .sclk(SCLK),
        .nrst(NRST),
        .chip_select_n(CHIP_SELECT_N),
        .sdi(SDI),
        .resp(st.resp),
        .sdo(SDO),
        .frame_word(frame_word),
        .frame_ok(frame_ok)
    );

    for (genvar i = 0; i < NUM_CH; i++)
    begin : g_retry
        lsw_retry_timer #(
            .WIDTH(TIMER_W)
        ) u_timer (
            .clk(CLK),
            .nrst(NRST),
            .run(retry_run[i]),
            .limit(retry_limit),
            .expired(retry_done[i])
        );
    end

    always_comb
    begin
        next_st = st;
        next_st.pin_meta = pin_raw;
        next_st.pin_sync = st.pin_meta;
        next_st.cs_prev = cs_n;

        // mode follows the sleep pin and the inputs; pin hold time is the
        // controller's duty, a short pulse may flip the mode briefly
        if (sleep_n)
        begin
            next_st.mode = MODE_NORMAL;
        end
        else if (in_a || in_b)
        begin
            next_st.mode = MODE_LIMP;
        end
        else
        begin
            next_st.mode = MODE_SLEEP;
        end

        spi_ok = (st.mode != MODE_SLEEP) && !dig_uv;
        regs_clr = !sleep_n || dig_uv;

        // frame word is still while select stays high, so sampling it after
        // the synchronised rising edge of select is safe
        frame_take = cs_n && !st.cs_prev && frame_ok && spi_ok;
        wr_addr = frame_word[FRM_ADDR_HI:FRM_ADDR_LO];
        wr_data = frame_word[FRM_DATA_HI:FRM_DATA_LO];

        oc_clr = '0;
        if (frame_take)
        begin
            next_st.rd_addr = wr_addr;
            if (frame_word[FRM_WRITE_BIT])
            begin
                unique case (wr_addr)
                    ADDR_ENABLE:
                    begin
                        next_st.enable = wr_data[NUM_CH-1:0];
                        oc_clr = wr_data[NUM_CH-1:0] & {NUM_CH{!regs_clr}};
                    end
                    ADDR_ROUTE_A: next_st.route_a = wr_data[NUM_CH-1:0];
                    ADDR_ROUTE_B: next_st.route_b = wr_data[NUM_CH-1:0];
                    ADDR_CUR_SRC: next_st.cur_src = wr_data[NUM_CH-1:0];
                    ADDR_RETRY_SEL: next_st.retry_sel = wr_data[1:0];
                    default:
                    begin
                        // status addresses ignore writes
                    end
                endcase
            end
        end

        if (regs_clr)
        begin
            next_st.enable = ENABLE_DEFAULT;
            next_st.route_a = ROUTE_A_DEFAULT;
            next_st.route_b = ROUTE_B_DEFAULT;
            next_st.cur_src = CUR_SRC_DEFAULT;
            next_st.retry_sel = RETRY_SEL_DEFAULT;
        end

        // limp home ignores the route registers
        limp_dem = '0;
        limp_dem[CH_A_DEFAULT] = in_a;
        limp_dem[CH_B_DEFAULT] = in_b;
        norm_dem = st.enable | ({NUM_CH{in_a}} & st.route_a)
                   | ({NUM_CH{in_b}} & st.route_b);

        unique case (st.mode)
            MODE_NORMAL: demand = norm_dem;
            MODE_LIMP: demand = limp_dem;
            MODE_SLEEP: demand = '0;
            default: demand = '0;
        endcase
        if (dig_uv && ana_uv)
        begin
            demand = '0;
        end

        // restart only for input-driven channels tripped in limp home
        retry_run = st.latch & limp_dem & {NUM_CH{st.mode == MODE_LIMP}};
        oc_clr = oc_clr | retry_done;

        // a new trip wins over a clear arriving in the same cycle
        oc_set = oc & st.chan;
        next_st.latch = (st.latch & ~oc_clr) | oc_set;
        if (st.mode == MODE_SLEEP)
        begin
            next_st.latch = oc_set;
        end

        // low analog supply: an off channel is not allowed to start
        next_st.chan = demand & ~next_st.latch & (st.chan | {NUM_CH{!ana_low}});
        next_st.isrc = st.cur_src & ~next_st.chan;

        next_st.uv_en = (st.mode != MODE_SLEEP);
        next_st.sdo_oe = spi_ok && !cs_n;

        rd_data = '0;
        unique case (st.rd_addr)
            ADDR_ENABLE: rd_data[NUM_CH-1:0] = st.enable;
            ADDR_ROUTE_A: rd_data[NUM_CH-1:0] = st.route_a;
            ADDR_ROUTE_B: rd_data[NUM_CH-1:0] = st.route_b;
            ADDR_CUR_SRC: rd_data[NUM_CH-1:0] = st.cur_src;
            ADDR_RETRY_SEL: rd_data[1:0] = st.retry_sel;
            ADDR_INPUT_MON: rd_data[1:0] = {in_b, in_a};
            ADDR_OC_LATCH: rd_data[NUM_CH-1:0] = st.latch;
            ADDR_MODE: rd_data[2:0] = st.mode;
        endcase
        // answer only changes between frames so the link sees a still word
        if (cs_n)
        begin
            next_st.resp = {1'b0, st.rd_addr, 4'h0, rd_data};
        end
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            st <= '0;
            st.pin_meta <= PIN_RESET;
            st.pin_sync <= PIN_RESET;
            st.cs_prev <= 1'b1;
            st.mode <= MODE_SLEEP;
            st.route_a <= ROUTE_A_DEFAULT;
            st.route_b <= ROUTE_B_DEFAULT;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign SDO_OE = st.sdo_oe;
    assign CHANNEL_ON = st.chan;
    assign CURRENT_SOURCE_ON = st.isrc;
    assign OC_LATCHED = st.latch;
    assign UV_DETECT_ENABLE = st.uv_en;
    assign MODE = st.mode;

endmodule : lsw_ctrl

// ### rtl/lsw_pkg.sv
package lsw_pkg;

    // core clock
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_PERIOD_NS = 25;

    // channels and serial frame
    localparam int NUM_CH = 4;
    localparam int FRAME_BITS = 16;
    localparam int FRAME_CNT_W = 4;
    localparam logic [FRAME_CNT_W-1:0] FRAME_LAST_BIT = 4'hF;
    localparam logic [FRAME_CNT_W-1:0] FRAME_FIRST_BIT = 4'h0;

    // frame fields
    localparam int FRM_WRITE_BIT = 15;
    localparam int FRM_ADDR_HI = 14;
    localparam int FRM_ADDR_LO = 12;
    localparam int FRM_DATA_HI = 7;
    localparam int FRM_DATA_LO = 0;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // register addresses inside a frame
    localparam logic [ADDR_W-1:0] ADDR_ENABLE = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_ROUTE_A = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_ROUTE_B = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_CUR_SRC = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_RETRY_SEL = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_INPUT_MON = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_OC_LATCH = 3'h6;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 3'h7;

    // default input routing
    localparam int CH_A_DEFAULT = 2;
    localparam int CH_B_DEFAULT = 3;
    localparam logic [NUM_CH-1:0] ROUTE_A_DEFAULT = 4'h4;
    localparam logic [NUM_CH-1:0] ROUTE_B_DEFAULT = 4'h8;
    localparam logic [NUM_CH-1:0] ENABLE_DEFAULT = 4'h0;
    localparam logic [NUM_CH-1:0] CUR_SRC_DEFAULT = 4'h0;
    localparam logic [1:0] RETRY_SEL_DEFAULT = 2'h0;

    // limp home restart: 10 ms base, each selector step doubles, limp home keeps the default
    localparam int RETRY0_MS = 10;
    localparam int RETRY0_CYCLES = RETRY0_MS * (CLK_HZ / 1000);
    localparam int RETRY_TIMER_W = 22;

    // pin synchroniser bit positions
    localparam int PIN_CS = 0;
    localparam int PIN_IN_A = 1;
    localparam int PIN_IN_B = 2;
    localparam int PIN_SLEEP_N = 3;
    localparam int PIN_DIG_UV = 4;
    localparam int PIN_ANA_UV = 5;
    localparam int PIN_ANA_LOW = 6;
    localparam int PIN_OC_LO = 7;
    localparam int PIN_W = 11;
    // sleep pin reads low out of reset so no false wake precedes the first sync
    localparam logic [PIN_W-1:0] PIN_RESET = 11'h001;

    typedef enum logic [2:0] {
        MODE_SLEEP = 3'b001,
        MODE_NORMAL = 3'b010,
        MODE_LIMP = 3'b100
    } lsw_mode_t;

endpackage : lsw_pkg

// ### rtl/lsw_retry_timer.sv
`timescale 1ns/10ps
module lsw_retry_timer #(
    parameter int WIDTH = 22
) (
    input wire logic clk, // core clock
    input wire logic nrst, // async reset, active low
    input wire logic run, // count while high, clears when low
    input wire logic [WIDTH-1:0] limit, // cycles to wait
    output logic expired // one-cycle pulse at the end of the wait
);
    import lsw_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic expired;
    } lsw_timer_t;

    lsw_timer_t st;
    lsw_timer_t next_st;

    always_comb
    begin
        next_st = st;
        next_st.expired = 1'b0;
        if (!run)
        begin
            next_st.cnt = '0;
        end
        else if (st.cnt >= limit)
        begin
            next_st.cnt = '0;
            next_st.expired = 1'b1;
        end
        else
        begin
            next_st.cnt = WIDTH'(st.cnt + 1'b1);
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign expired = st.expired;

endmodule : lsw_retry_timer

// ### rtl/lsw_spi_link.sv
`timescale 1ns/10ps
module lsw_spi_link (
    input wire logic sclk, // serial clock from the controller
    input wire logic nrst, // async reset, active low
    input wire logic chip_select_n, // frame select, active low
    input wire logic sdi, // serial data in
    input wire logic [15:0] resp, // answer word, held still during a frame
    output logic sdo, // serial data out
    output logic [15:0] frame_word, // last complete 16-bit word received
    output logic frame_ok // frame length was a multiple of 16
);
    import lsw_pkg::*;

    typedef struct packed {
        logic [FRAME_BITS-1:0] sh;
        logic [FRAME_BITS-1:0] word;
        logic ok;
    } lsw_rx_t;

    lsw_rx_t st;
    lsw_rx_t next_st;
    logic [FRAME_CNT_W-1:0] bit_cnt;
    logic link_rst_n;
    logic sdo_q;
    logic first;

    // counter restarts with every frame; sclk may be idle when select rises
    assign link_rst_n = nrst & ~chip_select_n;

    always_ff @(negedge sclk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            bit_cnt <= '0;
            first <= 1'b1;
        end
        else
        begin
            bit_cnt <= FRAME_CNT_W'(bit_cnt + 1'b1);
            first <= 1'b0;
        end
    end

    // sample on falling edge; received bits follow the answer so that a
    // chain of devices sees our input delayed by one frame
    always_comb
    begin
        next_st = st;
        // answer loads once per frame; later words pass the input through
        if (first)
        begin
            next_st.sh = {resp[FRAME_BITS-2:0], sdi};
        end
        else
        begin
            next_st.sh = {st.sh[FRAME_BITS-2:0], sdi};
        end
        next_st.ok = (bit_cnt == FRAME_LAST_BIT);
        if (bit_cnt == FRAME_LAST_BIT)
        begin
            next_st.word = next_st.sh;
        end
    end

    always_ff @(negedge sclk or negedge nrst)
    begin
        if (!nrst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // launch on rising edge, first bit taken from the answer word
    always_ff @(posedge sclk or negedge nrst)
    begin
        if (!nrst)
        begin
            sdo_q <= 1'b0;
        end
        else if (first)
        begin
            sdo_q <= resp[FRAME_BITS-1];
        end
        else
        begin
            sdo_q <= st.sh[FRAME_BITS-1];
        end
    end

    assign sdo = sdo_q;
    assign frame_word = st.word;
    assign frame_ok = st.ok;

endmodule : lsw_spi_link

// ### testbench/lsw_ctrl_checker.sv
`timescale 1ns/10ps
module lsw_ctrl_checker #(
    parameter int RETRY_BASE_CYCLES = lsw_pkg::RETRY0_CYCLES,
    parameter int TIMER_W = lsw_pkg::RETRY_TIMER_W
) (
    input wire logic CLK, // core clock
    input wire logic NRST, // async reset, active low
    input wire logic DIRECT_INPUT_A, // input pin a
    input wire logic DIRECT_INPUT_B, // input pin b
    input wire logic SLEEP_REQUEST_N, // sleep pin
    input wire logic DIGITAL_SUPPLY_UV, // digital undervoltage
    input wire logic ANALOG_SUPPLY_UV, // analog undervoltage
    input wire logic [3:0] OVERCURRENT, // overcurrent flags
    input wire logic SDO_OE, // serial output enable
    input wire logic [3:0] CHANNEL_ON, // stage commands
    input wire logic [3:0] CURRENT_SOURCE_ON, // current sources
    input wire logic [3:0] OC_LATCHED, // protection latches
    input wire logic UV_DETECT_ENABLE, // detectors on
    input wire lsw_pkg::lsw_mode_t MODE // operating mode
);
    import lsw_pkg::*;
    logic [31:0] held;

    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);

    // cycles the channel 2 latch has stood
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            held <= 32'h0;
        else
            held <= OC_LATCHED[2] ? held + 32'h1 : 32'h0;
    end

    sleep_off_a: assert property ($past(MODE) == MODE_SLEEP && MODE == MODE_SLEEP
        |-> CHANNEL_ON == 4'h0) else $error("channel on in sleep");
    uv_det_a: assert property (1 |=> UV_DETECT_ENABLE == ($past(MODE) != MODE_SLEEP))
        else $error("detector enable wrong");
    sleep_quiet_a: assert property ($past(MODE) == MODE_SLEEP && MODE == MODE_SLEEP
        |-> !SDO_OE) else $error("serial output in sleep");
    uv_quiet_a: assert property (DIGITAL_SUPPLY_UV [*4] |-> !SDO_OE)
        else $error("serial output in undervoltage");
    oc_off_a: assert property ((OC_LATCHED & CHANNEL_ON) == 4'h0)
        else $error("latched channel on");
    oc_set_a: assert property ((OVERCURRENT & CHANNEL_ON) != 4'h0
        |-> ##[1:4] OC_LATCHED != 4'h0) else $error("latch not set");
    src_off_a: assert property ((CURRENT_SOURCE_ON & CHANNEL_ON) == 4'h0)
        else $error("current source on an on channel");
    both_uv_a: assert property ((DIGITAL_SUPPLY_UV && ANALOG_SUPPLY_UV) [*4]
        |-> CHANNEL_ON == 4'h0) else $error("channel on in undervoltage");
    enter_limp_a: assert property ((DIRECT_INPUT_A && !SLEEP_REQUEST_N) [*4]
        |-> MODE == MODE_LIMP) else $error("limp home not entered");
    enter_sleep_a: assert property ((!DIRECT_INPUT_A && !DIRECT_INPUT_B && !SLEEP_REQUEST_N)
        [*4] |-> MODE == MODE_SLEEP) else $error("sleep not entered");
    restart_wait_a: assert property ($fell(OC_LATCHED[2]) && MODE == MODE_LIMP
        |-> held >= RETRY_BASE_CYCLES) else $error("restart too early");

    cover property (MODE == MODE_LIMP);
    cover property ($fell(OC_LATCHED[2]));
    cover property ($rose(SDO_OE));
endmodule : lsw_ctrl_checker

// ### testbench/lsw_spi_master.sv
`timescale 1ns/10ps
module lsw_spi_master (
    output logic sclk, // serial clock, idle low
    output logic cs_n, // frame select, active low
    output logic sdi, // data to the device
    input wire logic sdo, // data from the device
    input wire logic sdo_oe // device drives sdo
);
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    // clock stands still between frames; period fixed at 32 ns by this task
    task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx,
                        output logic oe);
        rx = 32'h0;
        oe = 1'b0;
        cs_n = 1'b0;
        #200;
        for (int i = nbits - 1; i >= 0; i--)
        begin
            sclk = 1'b1;
            sdi = tx[i];
            #16;
            rx[i] = sdo_oe ? sdo : 1'bz;
            oe = oe | sdo_oe;
            sclk = 1'b0;
            #16;
        end
        #200;
        cs_n = 1'b1;
        sdi = ~sdi; // released line must not look held
        #400;
    endtask : xfer
endmodule : lsw_spi_master

// ### testbench/testbench.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
    begin \
        cmp_count++; \
        if ((got) !== (ex)) \
        begin \
            errors++; \
            $display("FAIL %s expected %h seen %h", nm, ex, got); \
        end \
    end

module testbench;
    import lsw_pkg::*;
    localparam int RB = 20; // short restart keeps the run brief
    logic clk, nrst, in_a, in_b, sleep_n, dig_uv, ana_uv, ana_low;
    logic sclk, cs_n, sdi, sdo, sdo_oe, uv_en, oe;
    logic [3:0] oc, ch_on, cur_src, oc_lat;
    logic [31:0] r;
    lsw_mode_t mode;
    int errors = 0;
    int cmp_count = 0;
    int n;

    lsw_ctrl #(.RETRY_BASE_CYCLES(RB)) uut (.CLK(clk), .NRST(nrst), .SCLK(sclk),
        .CHIP_SELECT_N(cs_n), .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe), .DIRECT_INPUT_A(in_a),
        .DIRECT_INPUT_B(in_b), .SLEEP_REQUEST_N(sleep_n), .DIGITAL_SUPPLY_UV(dig_uv),
        .ANALOG_SUPPLY_UV(ana_uv), .ANALOG_SUPPLY_LOW(ana_low), .OVERCURRENT(oc),
        .CHANNEL_ON(ch_on), .CURRENT_SOURCE_ON(cur_src), .OC_LATCHED(oc_lat),
        .UV_DETECT_ENABLE(uv_en), .MODE(mode));
    lsw_spi_master u_mst (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : settle

    // pins held well past the sync delay
    task automatic pins(input logic a, input logic b, input logic s);
        @(posedge clk);
        in_a <= a;
        in_b <= b;
        sleep_n <= s;
        settle(6);
    endtask : pins

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        u_mst.xfer({16'h0, 1'b1, a, 4'h0, d}, 16, r, oe);
    endtask : wr

    // answer comes in the frame after the request
    task automatic rd(input logic [2:0] a, input logic [7:0] d);
        u_mst.xfer({16'h0, 1'b0, a, 12'h0}, 16, r, oe);
        u_mst.xfer({16'h0, 1'b0, a, 12'h0}, 16, r, oe);
        `CHK("read word", {1'b0, a, 4'h0, d}, r[15:0]);
    endtask : rd

    task automatic conclude();
        if (errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // the sequence needs well under 100 us
    initial
    begin
        #300000;
        errors++;
        conclude();
    end

    initial
    begin
        nrst = 1'b0;
        in_a = 1'b0;
        in_b = 1'b0;
        sleep_n = 1'b0;
        dig_uv = 1'b0;
        ana_uv = 1'b0;
        ana_low = 1'b0;
        oc = 4'h0;
        repeat (2) @(posedge clk);
        #1;
        `CHK("mode", MODE_SLEEP, mode);
        `CHK("chan", 4'h0, ch_on);
        @(posedge clk);
        nrst <= 1'b1;
        settle(6);
        `CHK("uv det", 1'b0, uv_en);
        pins(1'b0, 1'b0, 1'b1);
        `CHK("mode", MODE_NORMAL, mode);
        `CHK("uv det", 1'b1, uv_en);
        pins(1'b1, 1'b0, 1'b1);
        `CHK("chan", 4'h4, ch_on);
        pins(1'b1, 1'b1, 1'b1);
        `CHK("chan", 4'hC, ch_on);
        rd(ADDR_INPUT_MON, 8'h03);
        pins(1'b0, 1'b0, 1'b1);
        wr(ADDR_ENABLE, 8'h01);
        wr(ADDR_ROUTE_A, 8'h03);
        wr(ADDR_ROUTE_B, 8'h02);
        `CHK("chan", 4'h1, ch_on);
        pins(1'b1, 1'b0, 1'b1);
        `CHK("chan", 4'h3, ch_on);
        pins(1'b0, 1'b1, 1'b1);
        `CHK("chan", 4'h3, ch_on);
        rd(ADDR_ROUTE_B, 8'h02);
        wr(ADDR_RETRY_SEL, 8'h03);
        rd(ADDR_RETRY_SEL, 8'h03);
        pins(1'b0, 1'b0, 1'b1);
        wr(ADDR_CUR_SRC, 8'h0F);
        `CHK("cur src", 4'hE, cur_src);
        @(posedge clk);
        oc <= 4'h1;
        settle(6);
        `CHK("latch", 4'h1, oc_lat);
        @(posedge clk);
        oc <= 4'h0;
        settle(6);
        `CHK("chan", 4'h0, ch_on);
        wr(ADDR_ENABLE, 8'h01);
        `CHK("chan", 4'h1, ch_on);
        u_mst.xfer({1'b1, ADDR_ENABLE, 12'h00F, 1'b1, ADDR_ENABLE, 12'h002}, 32, r, oe);
        `CHK("chain out", {1'b1, ADDR_ENABLE, 12'h00F}, r[15:0]);
        `CHK("chan", 4'h2, ch_on);
        u_mst.xfer({8'h0, 1'b1, ADDR_ENABLE, 12'h008}, 24, r, oe);
        `CHK("chan", 4'h2, ch_on);
        @(posedge clk);
        ana_low <= 1'b1;
        wr(ADDR_ENABLE, 8'h06);
        `CHK("chan", 4'h2, ch_on);
        wr(ADDR_ENABLE, 8'h00);
        `CHK("chan", 4'h0, ch_on);
        @(posedge clk);
        ana_low <= 1'b0;
        wr(ADDR_ENABLE, 8'h02);
        @(posedge clk);
        dig_uv <= 1'b1;
        settle(6);
        `CHK("chan", 4'h0, ch_on);
        wr(ADDR_ENABLE, 8'h0F);
        `CHK("sdo drive", 1'b0, oe);
        @(posedge clk);
        dig_uv <= 1'b0;
        pins(1'b1, 1'b0, 1'b1);
        `CHK("chan", 4'h4, ch_on);
        @(posedge clk);
        dig_uv <= 1'b1;
        ana_uv <= 1'b1;
        settle(6);
        `CHK("chan", 4'h0, ch_on);
        @(posedge clk);
        dig_uv <= 1'b0;
        ana_uv <= 1'b0;
        settle(6);
        `CHK("chan", 4'h4, ch_on);
        wr(ADDR_ROUTE_A, 8'h03);
        pins(1'b1, 1'b1, 1'b0);
        `CHK("mode", MODE_LIMP, mode);
        `CHK("chan", 4'hC, ch_on);
        rd(ADDR_INPUT_MON, 8'h03);
        @(posedge clk);
        oc <= 4'h4;
        settle(6);
        `CHK("latch", 4'h4, oc_lat);
        @(posedge clk);
        oc <= 4'h0;
        n = 0;
        while (ch_on[2] !== 1'b1 && n < 4 * RB)
        begin
            settle(1);
            n++;
        end
        `CHK("restart", 1'b1, n + 4 >= RB && n + 4 <= RB + 5);
        pins(1'b0, 1'b0, 1'b0);
        `CHK("mode", MODE_SLEEP, mode);
        `CHK("chan", 4'h0, ch_on);
        `CHK("uv det", 1'b0, uv_en);
        wr(ADDR_ENABLE, 8'h0F);
        `CHK("sdo drive", 1'b0, oe);
        pins(1'b1, 1'b0, 1'b1);
        `CHK("chan", 4'h4, ch_on);
        conclude();
    end
endmodule : testbench

bind lsw_ctrl lsw_ctrl_checker #(.RETRY_BASE_CYCLES(RETRY_BASE_CYCLES), .TIMER_W(TIMER_W))
    u_chk (.CLK(CLK), .NRST(NRST), .DIRECT_INPUT_A(DIRECT_INPUT_A),
    .DIRECT_INPUT_B(DIRECT_INPUT_B), .SLEEP_REQUEST_N(SLEEP_REQUEST_N),
    .DIGITAL_SUPPLY_UV(DIGITAL_SUPPLY_UV), .ANALOG_SUPPLY_UV(ANALOG_SUPPLY_UV),
    .OVERCURRENT(OVERCURRENT), .SDO_OE(SDO_OE), .CHANNEL_ON(CHANNEL_ON),
    .CURRENT_SOURCE_ON(CURRENT_SOURCE_ON), .OC_LATCHED(OC_LATCHED),
    .UV_DETECT_ENABLE(UV_DETECT_ENABLE), .MODE(MODE));
